// *** shared/tlv_defines.svh ***
/*
  constants of the two level vectored interrupt handler: register indices,
  field positions, reset values, masks, vector layout and response counts.
  assumes it is included by bare name, once per file, by the handler rtl.
*/
`ifndef TLV_DEFINES_SVH
`define TLV_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define TLV_IDX_TIMER_CTL 8'h88
`define TLV_IDX_PRI_EN 8'hA8
`define TLV_IDX_PRI_PRIO 8'hB8
`define TLV_IDX_EXT_EN 8'hE6
`define TLV_IDX_EXT_PRIO 8'hF6
`define TLV_IDX_PENDING 8'h40
`define TLV_IDX_STATUS 8'h41

`define TLV_GLOBAL_EN_BIT 7
`define TLV_PRIO_RD_ONES 8'h80
`define TLV_EXT_WR_MASK 8'hB9
`define TLV_RST_BYTE 8'h00
`define TLV_RST_PEND 15'h0000

// pending flags inside the timer control register
`define TLV_TC_EXT0_BIT 1
`define TLV_TC_EXT1_BIT 3
`define TLV_TC_TMR0_BIT 5
`define TLV_TC_TMR1_BIT 7

// orders 8, 9 and 13 are reserved slots
`define TLV_ORDER_VALID 15'h5CFF
`define TLV_HW_CLEAR_LAST 4'h3
`define TLV_NUM_SOURCES 12

`define TLV_VEC_BASE 16'h0003
`define TLV_VEC_SHIFT 3
`define TLV_VEC_RESET 16'h0000

`define TLV_DETECT_CYC 1
`define TLV_CALL_CYC 4

`define TLV_RESP_OKAY 2'b00
`define TLV_RESP_SLVERR 2'b10

`endif

// *** shared/tlv_pkg.sv ***
/*
  types of the two level vectored interrupt handler.
  assumes the handler rtl refers to every item as tlv_pkg::name.
*/
package tlv_pkg;

  typedef struct packed {
    logic req;
    logic high;
    logic [3:0] idx;
    logic [15:0] addr;
  } tlv_vector_s;

  typedef enum logic [1:0] {
    TLV_W_COLLECT = 2'b01,
    TLV_W_RESP = 2'b10
  } tlv_wr_state_e;

  typedef enum logic [1:0] {
    TLV_R_IDLE = 2'b01,
    TLV_R_RESP = 2'b10
  } tlv_rd_state_e;

endpackage

// *** rtl/tlv_irq_handler.sv ***
/*
  two level vectored interrupt handler with an axi4-lite register slave.
  assumes source events and core strobes come from logic on mclk_in, one
  cycle pulses, and that the core performs the call and return itself.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
// Operation
// - twelve sources, each at one of two priority levels
// - pending flag sets on its event regardless of any enable
// - enabled pending flag raises a request for a call to its vector
// - disabled pending flag raises nothing and execution continues
// - source enables count only while global enable bit 7 is one
// - flags raised while globally disabled stay pending until re-enabled
// - vectoring clears only external input and timer 0/1 flags
// - flag still set after return raises a request again once the next instruction completes
// - software writing one to a flag acts as a real event; flags of orders 10, 11, 12 and 14 have no writable bit
// - high request preempts low routine; high routine is never preempted
// - all sources low after reset; one priority bit per source
// - high level first, then lowest order number within a level
// - pending requests sampled and decoded every clock
// - one detection cycle then a four cycle call, five in total
// - after a return at least one instruction runs before the next call
// - worst case latency is return plus divide plus detection and call
// - request waits while equal or higher level routine is running
// - vectors from 0x0003 in steps of eight; reset 0x0000; slots reserved
// - second external input is order 2, vector 0x0013, timer control bit 3
// - return resumes the interrupted flow and ends current level service
// - each source has its own enable bit in primary or extended register
// - global enable one lets sources follow own masks, zero blocks all
// - priority bit one means high level, zero means low level
`timescale 1ns/1ps
`include "tlv_defines.svh"

module tlv_irq_handler #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [14:0] src_event_in,
  input wire logic core_ack_in,
  input wire logic core_reti_in,
  input wire logic core_instr_done_in,
  output tlv_pkg::tlv_vector_s vector_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // spread a primary/extended register pair onto the fifteen order slots
  function automatic logic [14:0] tlv_by_order(input logic [7:0] pri, input logic [7:0] ext);
    tlv_by_order = {ext[7], 1'b0, ext[5], ext[4], ext[3], 2'b00, ext[0], pri[6:0]};
  endfunction

  // lowest order number wins within one level
  function automatic logic [3:0] tlv_first(input logic [14:0] vec);
    tlv_first = 4'hF;
    for (int i = 14; i >= 0; i--) begin
      if (vec[i]) begin
        tlv_first = 4'(i);
      end
    end
  endfunction

  function automatic logic tlv_is_reg(input logic [7:0] idx);
    tlv_is_reg = (idx == `TLV_IDX_TIMER_CTL) || (idx == `TLV_IDX_PRI_EN) ||
                 (idx == `TLV_IDX_PRI_PRIO) || (idx == `TLV_IDX_EXT_EN) ||
                 (idx == `TLV_IDX_EXT_PRIO) || (idx == `TLV_IDX_PENDING) ||
                 (idx == `TLV_IDX_STATUS);
  endfunction

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  logic [7:0] timer_ctl_q;
  logic [7:0] primary_irq_enable_reg_q;
  logic [7:0] primary_priority_reg_q;
  logic [7:0] extended_irq_enable_reg_q;
  logic [7:0] extended_priority_reg_q;
  logic [14:0] pend_q;
  logic [14:0] pend_d;
  logic ins_low_q;
  logic ins_high_q;
  logic hold_q;
  tlv_pkg::tlv_vector_s vec_q;
  tlv_pkg::tlv_vector_s vec_d;
  tlv_pkg::tlv_wr_state_e wr_state_q;
  tlv_pkg::tlv_rd_state_e rd_state_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_idx_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic wr_do;
  logic [7:0] rd_idx;
  logic [14:0] enable_by_order;
  logic [14:0] high_by_order;
  logic [14:0] eligible;
  logic [14:0] elig_high;
  logic [14:0] elig_low;
  logic global_irq_enable;
  logic [7:0] timer_ctl_rd;
  logic [31:0] rd_word;

  assign global_irq_enable = primary_irq_enable_reg_q[`TLV_GLOBAL_EN_BIT];
  assign enable_by_order = tlv_by_order(primary_irq_enable_reg_q, extended_irq_enable_reg_q);
  assign high_by_order = tlv_by_order(primary_priority_reg_q, extended_priority_reg_q);
  // a disabled flag simply never reaches the arbiter
  assign eligible = pend_q & enable_by_order & {15{global_irq_enable}};
  assign elig_high = eligible & high_by_order;
  assign elig_low = eligible & ~high_by_order;
  assign wr_do = (wr_state_q == tlv_pkg::TLV_W_COLLECT) && aw_have_q && w_have_q;
  assign rd_idx = s_axi_araddr_in[9:2];

  // flags of both external inputs and both timers live in timer control
  assign timer_ctl_rd = {pend_q[3], timer_ctl_q[6], pend_q[1], timer_ctl_q[4],
                         pend_q[2], timer_ctl_q[2], pend_q[0], timer_ctl_q[0]};

  // pending flags: a new event wins over any clear in the same cycle
  always_comb begin
    pend_d = pend_q;
    if (core_ack_in && (vec_q.idx <= `TLV_HW_CLEAR_LAST)) begin
      pend_d[vec_q.idx] = 1'b0;
    end
    if (wr_do && w_lane0_q && (aw_idx_q == `TLV_IDX_TIMER_CTL)) begin
      pend_d[0] = w_byte_q[`TLV_TC_EXT0_BIT];
      pend_d[1] = w_byte_q[`TLV_TC_TMR0_BIT];
      pend_d[2] = w_byte_q[`TLV_TC_EXT1_BIT];
      pend_d[3] = w_byte_q[`TLV_TC_TMR1_BIT];
    end
    if (wr_do && w_lane0_q && (aw_idx_q == `TLV_IDX_PENDING)) begin
      pend_d[7:4] = w_byte_q[7:4];
    end
    pend_d = (pend_d | src_event_in) & `TLV_ORDER_VALID;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_q <= `TLV_RST_PEND;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_ctl_q <= `TLV_RST_BYTE;
      primary_irq_enable_reg_q <= `TLV_RST_BYTE;
      primary_priority_reg_q <= `TLV_RST_BYTE;
      extended_irq_enable_reg_q <= `TLV_RST_BYTE;
      extended_priority_reg_q <= `TLV_RST_BYTE;
    end else if (wr_do && w_lane0_q) begin
      case (aw_idx_q)
        `TLV_IDX_TIMER_CTL: timer_ctl_q <= w_byte_q;
        `TLV_IDX_PRI_EN: primary_irq_enable_reg_q <= w_byte_q;
        `TLV_IDX_PRI_PRIO: primary_priority_reg_q <= w_byte_q & ~`TLV_PRIO_RD_ONES;
        `TLV_IDX_EXT_EN: extended_irq_enable_reg_q <= w_byte_q & `TLV_EXT_WR_MASK;
        `TLV_IDX_EXT_PRIO: extended_priority_reg_q <= w_byte_q & `TLV_EXT_WR_MASK;
        default: ;
      endcase
    end
  end

  // in-service stack: high sits above low, a return pops the top level
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ins_low_q <= 1'b0;
      ins_high_q <= 1'b0;
    end else if (core_ack_in) begin
      if (vec_q.high) begin
        ins_high_q <= 1'b1;
      end else begin
        ins_low_q <= 1'b1;
      end
    end else if (core_reti_in) begin
      if (ins_high_q) begin
        ins_high_q <= 1'b0;
      end else begin
        ins_low_q <= 1'b0;
      end
    end
  end

  // after a return one more instruction must finish before the next call
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold_q <= 1'b0;
    end else if (core_reti_in) begin
      hold_q <= 1'b1;
    end else if (core_instr_done_in) begin
      hold_q <= 1'b0;
    end
  end

  // one cycle of detection; the core adds its four cycle call
  always_comb begin
    vec_d.high = |elig_high;
    vec_d.idx = vec_d.high ? tlv_first(elig_high) : tlv_first(elig_low);
    vec_d.addr = 16'(`TLV_VEC_BASE + ({12'h000, vec_d.idx} << `TLV_VEC_SHIFT));
    vec_d.req = (|eligible) && !hold_q && !core_ack_in && !core_reti_in &&
                !ins_high_q && (vec_d.high || !ins_low_q);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      vec_q <= '{req: 1'b0, high: 1'b0, idx: 4'h0, addr: `TLV_VEC_RESET};
    end else begin
      vec_q <= vec_d;
    end
  end

  assign vector_out = vec_q;

  // axi4-lite write side; address and data may arrive in either order
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_state_q <= tlv_pkg::TLV_W_COLLECT;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `TLV_RESP_OKAY;
    end else begin
      case (wr_state_q)
        tlv_pkg::TLV_W_COLLECT: begin
          if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr_in[9:2];
            s_axi_awready_out <= 1'b0;
          end
          if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_q <= 1'b1;
            w_byte_q <= s_axi_wdata_in[7:0];
            w_lane0_q <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
          end
          if (wr_do) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= tlv_is_reg(aw_idx_q) ? `TLV_RESP_OKAY : `TLV_RESP_SLVERR;
            wr_state_q <= tlv_pkg::TLV_W_RESP;
          end
        end
        tlv_pkg::TLV_W_RESP: begin
          if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            wr_state_q <= tlv_pkg::TLV_W_COLLECT;
          end
        end
        default: wr_state_q <= tlv_pkg::TLV_W_COLLECT;
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      `TLV_IDX_TIMER_CTL: rd_word[7:0] = timer_ctl_rd;
      `TLV_IDX_PRI_EN: rd_word[7:0] = primary_irq_enable_reg_q;
      `TLV_IDX_PRI_PRIO: rd_word[7:0] = primary_priority_reg_q | `TLV_PRIO_RD_ONES;
      `TLV_IDX_EXT_EN: rd_word[7:0] = extended_irq_enable_reg_q;
      `TLV_IDX_EXT_PRIO: rd_word[7:0] = extended_priority_reg_q;
      `TLV_IDX_PENDING: rd_word[14:0] = pend_q;
      `TLV_IDX_STATUS: rd_word[23:0] = {vec_q.addr, ins_high_q, ins_low_q, hold_q,
                                        vec_q.req, vec_q.idx};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // axi4-lite read side; the answer comes one cycle after the address is taken
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_state_q <= tlv_pkg::TLV_R_IDLE;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `TLV_RESP_OKAY;
    end else begin
      case (rd_state_q)
        tlv_pkg::TLV_R_IDLE: begin
          if (s_axi_arvalid_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= tlv_is_reg(rd_idx) ? `TLV_RESP_OKAY : `TLV_RESP_SLVERR;
            rd_state_q <= tlv_pkg::TLV_R_RESP;
          end
        end
        tlv_pkg::TLV_R_RESP: begin
          if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
            rd_state_q <= tlv_pkg::TLV_R_IDLE;
          end
        end
        default: rd_state_q <= tlv_pkg::TLV_R_IDLE;
      endcase
    end
  end

  property p_event_sets_flag;
    src_event_in[5] |=> pend_q[5];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag)
    else $error("source event did not set its pending flag");

  property p_hw_clear_ext0;
    core_ack_in && (vec_q.idx == 4'h0) && !src_event_in[0] && !wr_do |=> !pend_q[0];
  endproperty
  a_hw_clear_ext0: assert property (p_hw_clear_ext0)
    else $error("external input flag not cleared on vectoring");

  property p_sw_flag_kept;
    core_ack_in && (vec_q.idx == 4'h4) && pend_q[4] && !wr_do |=> pend_q[4];
  endproperty
  a_sw_flag_kept: assert property (p_sw_flag_kept)
    else $error("software cleared flag was cleared by hardware");

  property p_global_mask;
    !global_irq_enable |=> !vector_out.req;
  endproperty
  a_global_mask: assert property (p_global_mask)
    else $error("request raised while globally disabled");

  property p_high_never_preempted;
    ins_high_q |=> !vector_out.req;
  endproperty
  a_high_never_preempted: assert property (p_high_never_preempted)
    else $error("request raised over a high level routine");

  property p_low_only_by_high;
    vector_out.req && ins_low_q |-> vector_out.high;
  endproperty
  a_low_only_by_high: assert property (p_low_only_by_high)
    else $error("low routine preempted by a low request");

  property p_return_hold;
    core_reti_in ##1 !core_instr_done_in |=> !vector_out.req;
  endproperty
  a_return_hold: assert property (p_return_hold)
    else $error("request raised before the instruction after return");

  property p_detect_one_cycle;
    (|elig_high) && !hold_q && !ins_high_q && !core_ack_in && !core_reti_in
      |-> ##`TLV_DETECT_CYC vector_out.req && vector_out.high;
  endproperty
  a_detect_one_cycle: assert property (p_detect_one_cycle)
    else $error("eligible high request not raised after one cycle");

  property p_vector_addr;
    vector_out.req |-> vector_out.addr == 16'(`TLV_VEC_BASE + 16'(vector_out.idx) * 16'h0008);
  endproperty
  a_vector_addr: assert property (p_vector_addr)
    else $error("vector address does not match its order");

  property p_stack_unwind;
    core_reti_in && ins_high_q && ins_low_q && !core_ack_in |=> ins_low_q && !ins_high_q;
  endproperty
  a_stack_unwind: assert property (p_stack_unwind)
    else $error("nested return did not fall back to low service");

  property p_reserved_slots;
    !pend_q[8] && !pend_q[9] && !pend_q[13];
  endproperty
  a_reserved_slots: assert property (p_reserved_slots)
    else $error("reserved slot flag became pending");

endmodule

// *** verif/tlv_core_model.sv ***
/*
  behavioural model of the processor core facing the interrupt handler.
  assumes the bench permits each call with take_in and commands each
  return with ret_in; slow_in stretches every instruction to 8 cycles.
*/
`timescale 1ns/1ps
module tlv_core_model (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input tlv_pkg::tlv_vector_s vector_in,
  input wire logic take_in,
  input wire logic slow_in,
  input wire logic ret_in,
  output logic core_ack_out,
  output logic core_reti_out,
  output logic core_instr_done_out
);
  logic [2:0] step_q;

  // slow mode stands for a long divide after a return
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      step_q <= 3'h0;
      core_instr_done_out <= 1'b0;
    end else begin
      step_q <= slow_in ? step_q + 3'h1 : 3'h0;
      core_instr_done_out <= (step_q == 3'h0);
    end
  end

  // the call starts only at an instruction boundary, one pulse per request
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_ack_out <= 1'b0;
    end else begin
      core_ack_out <= vector_in.req && take_in && core_instr_done_out && !core_ack_out;
    end
  end

  assign core_reti_out = ret_in;
endmodule

// *** verif/tlv_irq_handler_tb.sv ***
/*
  self-checking bench of the two level vectored interrupt handler.
  assumes the core model in tlv_core_model.sv and the shared defines;
  registers are reached over axi4-lite at four times their index.
*/
`timescale 1ns/1ps
`include "tlv_defines.svh"
module tlv_irq_handler_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] ev = 15'h0000;
  logic take = 1'b0;
  logic slow = 1'b0;
  logic ret = 1'b0;
  logic ack, reti, done;
  tlv_pkg::tlv_vector_s vec;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic [14:0] en;
  logic d;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;

  always #25 clk = ~clk;

  tlv_irq_handler tlv_irq_handler_i (
    .mclk_in(clk), .sys_rst_in(rst), .src_event_in(ev), .core_ack_in(ack),
    .core_reti_in(reti), .core_instr_done_in(done), .vector_out(vec),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
  );

  tlv_core_model tlv_core_model_i (
    .mclk_in(clk), .sys_rst_in(rst), .vector_in(vec), .take_in(take), .slow_in(slow),
    .ret_in(ret), .core_ack_out(ack), .core_reti_out(reti), .core_instr_done_out(done)
  );

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hang in any handshake wait ends here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, `TLV_RESP_OKAY);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] v);
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    rdr(idx, rd);
    chk(rr, `TLV_RESP_OKAY);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [14:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 15'h0000;
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
      chk(vec.req, 1'b0);
    end
  endtask

  task automatic reti_cmd();
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask

  // wait for a request, check its vector, then let the core take it
  task automatic serve(input logic [3:0] i, input logic h);
    int k;
    k = 0;
    #1;
    while (vec.req !== 1'b1 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(vec.req, 1'b1);
    chk(vec.idx, i);
    chk(vec.addr, `TLV_VEC_BASE + ({12'h000, i} << `TLV_VEC_SHIFT));
    chk(vec.high, h);
    @(posedge clk);
    take <= 1'b1;
    k = 0;
    #1;
    while (ack !== 1'b1 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(ack, 1'b1);
    @(posedge clk);
    take <= 1'b0;
  endtask

  initial begin
    static logic [7:0] ridx [6] = '{`TLV_IDX_PRI_EN, `TLV_IDX_PRI_PRIO, `TLV_IDX_EXT_EN,
      `TLV_IDX_EXT_PRIO, `TLV_IDX_TIMER_CTL, `TLV_IDX_PENDING};
    static logic [31:0] rrst [6] = '{32'h00, 32'h80, 32'h00, 32'h00, 32'h00, 32'h00};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(vec, 32'h0);
    // bus side idles ready for both directions with no answer standing
    chk({awready, wready, arready, bvalid, rvalid}, 32'h1C);
    for (int j = 0; j < 6; j++) begin
      rc(ridx[j], rrst[j]);
    end
    rdr(8'h00, rd);
    chk(rr, `TLV_RESP_SLVERR);
    // flag held while globally disabled, served once enabled
    wr(`TLV_IDX_PRI_EN, 8'h01);
    pulse(15'h0001);
    quiet(4);
    rc(`TLV_IDX_TIMER_CTL, 32'h02);
    wr(`TLV_IDX_PRI_EN, 8'h81);
    serve(4'h0, 1'b0);
    rc(`TLV_IDX_TIMER_CTL, 32'h00);
    reti_cmd();
    // one detection cycle before the request
    pulse(15'h0001);
    #1;
    chk(vec.req, 1'b0);
    @(posedge clk);
    #1;
    chk(vec.req, 1'b1);
    serve(4'h0, 1'b0);
    reti_cmd();
    // software-cleared flag re-enters after one slow instruction
    wr(`TLV_IDX_PRI_EN, 8'h90);
    pulse(15'h0010);
    serve(4'h4, 1'b0);
    rc(`TLV_IDX_PENDING, 32'h10);
    rc(`TLV_IDX_STATUS, 32'h0000_2344);
    slow <= 1'b1;
    reti_cmd();
    d = 1'b0;
    n = 0;
    #1;
    while (vec.req !== 1'b1 && n < 40) begin
      d = d | (done === 1'b1);
      @(posedge clk);
      #1;
      n++;
    end
    chk(d, 1'b1);
    serve(4'h4, 1'b0);
    wr(`TLV_IDX_PENDING, 8'h00);
    reti_cmd();
    quiet(12);
    @(posedge clk);
    slow <= 1'b0;
    // arbitration and nesting
    wr(`TLV_IDX_PRI_EN, 8'hA2);
    pulse(15'h0022);
    serve(4'h1, 1'b0);
    reti_cmd();
    serve(4'h5, 1'b0);
    wr(`TLV_IDX_PENDING, 8'h00);
    reti_cmd();
    wr(`TLV_IDX_PRI_PRIO, 8'h20);
    rc(`TLV_IDX_PRI_PRIO, 32'hA0);
    pulse(15'h0022);
    serve(4'h5, 1'b1);
    quiet(6);
    wr(`TLV_IDX_PENDING, 8'h00);
    reti_cmd();
    serve(4'h1, 1'b0);
    pulse(15'h0020);
    serve(4'h5, 1'b1);
    pulse(15'h0020);
    quiet(6);
    wr(`TLV_IDX_PENDING, 8'h00);
    pulse(15'h0002);
    reti_cmd();
    quiet(6);
    reti_cmd();
    serve(4'h1, 1'b0);
    reti_cmd();
    // software set of the second external input flag
    wr(`TLV_IDX_PRI_PRIO, 8'h00);
    wr(`TLV_IDX_PRI_EN, 8'h84);
    wr(`TLV_IDX_TIMER_CTL, 8'h08);
    serve(4'h2, 1'b0);
    rc(`TLV_IDX_TIMER_CTL, 32'h00);
    reti_cmd();
    // every valid order, then its enable removed
    en = `TLV_ORDER_VALID;
    wr(`TLV_IDX_PRI_EN, 8'hFF);
    wr(`TLV_IDX_EXT_EN, 8'hFF);
    rc(`TLV_IDX_EXT_EN, 32'hB9);
    for (int o = 0; o < 15; o++) begin
      if (en[o]) begin
        pulse(15'h0001 << o);
        serve(o[3:0], 1'b0);
        en[o] = 1'b0;
        wr(`TLV_IDX_PRI_EN, {1'b1, en[6:0]});
        wr(`TLV_IDX_EXT_EN, {en[14], 1'b0, en[12:10], 2'b00, en[7]});
        reti_cmd();
      end
    end
    quiet(6);
    summarize();
  end
endmodule
